/* common/spg_pkg.sv */
// Package for the spare pin GPIO block: register map, fields, codes.
// Assumes an AXI4-Lite slave with 32-bit data and one word per register.
`default_nettype none
package spg_pkg;
  // Bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Register indices and reset value; byte address is four times the index
  localparam logic [7:0] IDX_PAGE = 8'h00;
  localparam logic [7:0] IDX_GPIO_A = 8'h64;
  localparam logic [7:0] IDX_GPIO_B = 8'h65;
  localparam logic [7:0] REG_RST = 8'h00;
  // Writable bit masks
  localparam logic [7:0] PAGE_WMASK = 8'h01;
  localparam logic [7:0] A_WMASK = 8'hee;
  localparam logic [7:0] B_WMASK = 8'h37;
  // Page register field
  localparam int PAGE_BIT = 0;
  // Bus pin register fields
  localparam int A_SDA_MODE_HI = 7;
  localparam int A_SDA_MODE_LO = 6;
  localparam int A_SDA_LVL = 5;
  localparam int A_SDA_IN = 4;
  localparam int A_SCL_MODE_HI = 3;
  localparam int A_SCL_MODE_LO = 2;
  localparam int A_SCL_LVL = 1;
  localparam int A_SCL_IN = 0;
  // Multifunction pin register fields
  localparam int B_ADDR0 = 7;
  localparam int B_ADDR1 = 6;
  localparam int B_IN_EN = 5;
  localparam int B_SDIN_EN = 4;
  localparam int B_IN_VAL = 3;
  localparam int B_OUT_EN = 2;
  localparam int B_OUT_LVL = 1;
  localparam int B_CLK_SRC = 0;
  // Synchroniser depth and strap settling wait in cycles
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Pin mode codes
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_IN = 2'h1,
    MODE_OUT = 2'h2,
    MODE_RSVD = 2'h3
  } spg_mode_type;
  // Register select after decode
  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_PAGE = 2'h1,
    SEL_A = 2'h3,
    SEL_B = 2'h2
  } spg_sel_type;
  // Strap capture sequence
  typedef enum logic [1:0] {
    ST_SETTLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_HELD = 2'h3
  } spg_strap_type;
endpackage
`default_nettype wire

/* common/spg_pin_if.sv */
// Interface carrying synchronised pin levels to the register logic.
// Assumes all members are in the aclk domain.
`timescale 1ns/10ps
`default_nettype none
interface spg_pin_if;
  logic sda;
  logic scl;
  logic sel;
  logic addr0;
  logic addr1;
  logic spare_in;
  modport sync (output sda, scl, sel, addr0, addr1, spare_in);
  modport core (input sda, scl, sel, addr0, addr1, spare_in);
endinterface
`default_nettype wire

/* logic/spg_pin_sync.sv */
// Two-stage synchroniser bank for all pin inputs of the block.
// Assumes pins are asynchronous to aclk; reset is synchronous, low.
`timescale 1ns/10ps
`default_nettype none
module spg_pin_sync
  import spg_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sda_in,
  input wire logic scl_in,
  input wire logic iface_select,
  input wire logic addr_bit0_pin,
  input wire logic addr_bit1_pin,
  input wire logic spare_input_pin,
  spg_pin_if.sync pins
);
  localparam int W = 6;
  logic [W-1:0] raw;
  logic [W-1:0] stage_r [STAGES];

  // Gather the raw levels
  assign raw = {sda_in, scl_in, iface_select, addr_bit0_pin,
                addr_bit1_pin, spare_input_pin};

  // Shift chain; only the next stage reads each flop, and only the output reads the last
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_r[i] <= '0;
      end
    end else begin
      stage_r[0] <= raw;
      for (int i = 1; i < STAGES; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  // Hand out the settled levels
  assign {pins.sda, pins.scl, pins.sel, pins.addr0, pins.addr1,
          pins.spare_in} = stage_r[STAGES-1];
endmodule
`default_nettype wire

/* logic/spg_gpio_top.sv */
// Top of the spare pin GPIO block: AXI4-Lite registers and pin logic.
// Assumes pins are asynchronous and the normal-function drive inputs
// come from logic clocked on aclk.
`timescale 1ns/10ps
`default_nettype none
module spg_gpio_top
  import spg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [spg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [spg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [spg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [spg_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interface strap: one selects SPI, zero selects I2C
  input wire logic iface_select,
  // Control bus data pin, open drain
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Control bus clock pin, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  // Normal-function pull-down requests for the bus pins
  input wire logic func_sda_pull_low,
  input wire logic func_scl_pull_low,
  // Address strap pins
  input wire logic addr_bit0_pin,
  input wire logic addr_bit1_pin,
  // Spare input pin and its audio serial data route
  input wire logic spare_input_pin,
  output logic serial_data_in,
  // Spare output pin and its normal-function drive
  output logic spare_output_pin,
  output logic spare_output_oe_n,
  input wire logic func_spare_out,
  input wire logic func_spare_oe_n,
  // Core clock mux select: one takes plain_divided_clock
  output logic core_clock_use_plain
);
  import spg_pkg::*;

  spg_pin_if pins ();

  logic [7:0] page_r;
  logic [7:0] ctl_a_r;
  logic [7:0] ctl_b_r;
  logic addr0_r;
  logic addr1_r;
  spg_strap_type strap_r;
  logic [1:0] settle_r;
  logic aw_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_held_r;
  logic [DATA_W-1:0] w_data_r;
  logic w_lane0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic sda_oe_n_r;
  logic scl_oe_n_r;
  logic spare_out_r;
  logic spare_oe_n_r;
  logic sdin_r;

  logic aw_fire;
  logic w_fire;
  logic do_write;
  logic ar_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic wr_lane0;
  spg_sel_type wr_sel;
  spg_sel_type rd_sel;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;
  logic spi_mode;
  logic i2c_mode;
  spg_mode_type sda_mode;
  spg_mode_type scl_mode;
  logic sda_gp_in;
  logic sda_gp_out;
  logic scl_gp_in;
  logic scl_gp_out;
  logic spare_gp_in;
  logic spare_gp_out;
  logic spare_sdin;
  logic [7:0] stat_a;
  logic [7:0] stat_b;

  // Word address to register select, honouring the active page
  function automatic spg_sel_type decode(
    input logic [ADDR_W-1:0] addr,
    input logic page1
  );
    logic [ADDR_W-3:0] idx;
    spg_sel_type sel;
    idx = addr[ADDR_W-1:2];
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      if (idx == (ADDR_W-2)'(IDX_PAGE)) begin
        sel = SEL_PAGE;
      end else if (!page1 && idx == (ADDR_W-2)'(IDX_GPIO_A)) begin
        sel = SEL_A;
      end else if (!page1 && idx == (ADDR_W-2)'(IDX_GPIO_B)) begin
        sel = SEL_B;
      end
    end
    return sel;
  endfunction

  // Merge writable bits of a byte under a mask
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [7:0] data,
    input logic [7:0] mask
  );
    return (old & ~mask) | (data & mask);
  endfunction

  spg_pin_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .sda_in(sda_in),
    .scl_in(scl_in),
    .iface_select(iface_select),
    .addr_bit0_pin(addr_bit0_pin),
    .addr_bit1_pin(addr_bit1_pin),
    .spare_input_pin(spare_input_pin),
    .pins(pins)
  );

  // Strap and mode qualification
  assign spi_mode = pins.sel;
  assign i2c_mode = !pins.sel;
  assign sda_mode = spg_mode_type'(ctl_a_r[A_SDA_MODE_HI:A_SDA_MODE_LO]);
  assign scl_mode = spg_mode_type'(ctl_a_r[A_SCL_MODE_HI:A_SCL_MODE_LO]);

  // Effective general purpose uses; reserved code counts as none
  assign sda_gp_in = spi_mode && sda_mode == MODE_IN;
  assign sda_gp_out = spi_mode && sda_mode == MODE_OUT;
  assign scl_gp_in = spi_mode && scl_mode == MODE_IN;
  assign scl_gp_out = spi_mode && scl_mode == MODE_OUT;
  assign spare_gp_in = i2c_mode && ctl_b_r[B_IN_EN];
  assign spare_sdin = i2c_mode && ctl_b_r[B_SDIN_EN];
  assign spare_gp_out = i2c_mode && ctl_b_r[B_OUT_EN];

  // Read-only bits of both registers: live input levels, latched straps
  always_comb begin
    stat_a = REG_RST;
    stat_a[A_SDA_IN] = sda_gp_in && pins.sda;
    stat_a[A_SCL_IN] = scl_gp_in && pins.scl;
    stat_b = REG_RST;
    stat_b[B_ADDR0] = addr0_r;
    stat_b[B_ADDR1] = addr1_r;
    stat_b[B_IN_VAL] = spare_gp_in && pins.spare_in;
  end

  // Address strap capture once the synchroniser has settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_r <= ST_SETTLE;
      settle_r <= 2'h0;
    end else begin
      unique case (strap_r)
        ST_SETTLE: begin
          settle_r <= settle_r + 2'h1;
          if (settle_r == STRAP_WAIT - 2'h1) begin
            strap_r <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: strap_r <= ST_HELD;
        ST_HELD: strap_r <= ST_HELD;
        default: strap_r <= ST_SETTLE;
      endcase
    end
  end

  // Latched address levels, taken in the sample state only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr0_r <= 1'b0;
      addr1_r <= 1'b0;
    end else if (strap_r == ST_SAMPLE) begin
      addr0_r <= pins.addr0;
      addr1_r <= pins.addr1;
    end
  end

  // Write channel handshakes; both halves held until the response
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_lane0 = w_held_r ? w_lane0_r : s_axi_wstrb[0];
  assign do_write = (aw_held_r || aw_fire) && (w_held_r || w_fire);
  assign wr_sel = decode(wr_addr, page_r[PAGE_BIT]);
  assign wr_byte = wr_data[7:0];

  // Hold whichever half came first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_lane0_r <= 1'b0;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
      end
    end
  end

  // Write response, one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Page select register, visible on both pages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_r <= REG_RST;
    end else if (do_write && wr_lane0 && wr_sel == SEL_PAGE) begin
      page_r <= merge(page_r, wr_byte, PAGE_WMASK);
    end
  end

  // Bus pin control register; input bits are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_a_r <= REG_RST;
    end else if (do_write && wr_lane0 && wr_sel == SEL_A) begin
      ctl_a_r <= merge(ctl_a_r, wr_byte, A_WMASK);
    end
  end

  // Multifunction register; strap and input bits are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_b_r <= REG_RST;
    end else if (do_write && wr_lane0 && wr_sel == SEL_B) begin
      ctl_b_r <= merge(ctl_b_r, wr_byte, B_WMASK);
    end
  end

  // Read channel; one read at a time
  assign s_axi_arready = !rvalid_r;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign rd_sel = decode(s_axi_araddr, page_r[PAGE_BIT]);

  // Read byte assembly
  always_comb begin
    unique case (rd_sel)
      SEL_PAGE: rd_byte = page_r & PAGE_WMASK;
      SEL_A: rd_byte = (ctl_a_r & A_WMASK) | stat_a;
      SEL_B: rd_byte = (ctl_b_r & B_WMASK) | stat_b;
      SEL_NONE: rd_byte = REG_RST;
    endcase
  end

  // Read data, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rresp_r <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      rdata_r <= {{(DATA_W-8){1'b0}}, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Open-drain bus pins: enable only to pull low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_oe_n_r <= 1'b1;
      scl_oe_n_r <= 1'b1;
    end else begin
      if (sda_gp_out) begin
        sda_oe_n_r <= ctl_a_r[A_SDA_LVL];
      end else if (sda_gp_in) begin
        sda_oe_n_r <= 1'b1;
      end else begin
        sda_oe_n_r <= !func_sda_pull_low;
      end
      if (scl_gp_out) begin
        scl_oe_n_r <= ctl_a_r[A_SCL_LVL];
      end else if (scl_gp_in) begin
        scl_oe_n_r <= 1'b1;
      end else begin
        scl_oe_n_r <= !func_scl_pull_low;
      end
    end
  end

  // The bus pins never drive high
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_n = sda_oe_n_r;
  assign scl_oe_n = scl_oe_n_r;

  // Spare output pin: general output or its normal function
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spare_out_r <= 1'b0;
      spare_oe_n_r <= 1'b1;
    end else if (spare_gp_out) begin
      spare_out_r <= ctl_b_r[B_OUT_LVL];
      spare_oe_n_r <= 1'b0;
    end else begin
      spare_out_r <= func_spare_out;
      spare_oe_n_r <= func_spare_oe_n;
    end
  end

  assign spare_output_pin = spare_out_r;
  assign spare_output_oe_n = spare_oe_n_r;

  // Spare input routed to audio serial data when enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdin_r <= 1'b0;
    end else begin
      sdin_r <= spare_sdin && pins.spare_in;
    end
  end

  assign serial_data_in = sdin_r;

  // Core clock source selection level
  assign core_clock_use_plain = ctl_b_r[B_CLK_SRC];

endmodule
`default_nettype wire

/* bench/spg_pin_model.sv */
// Pin-side model: pull-up resistors on the open-drain bus pins and
// an outside device that may pull either line low.
// Assumes the enables come straight from the block's pin outputs.
`timescale 1ns/10ps
`default_nettype none
module spg_pin_model (
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic ext_sda_low,
  input wire logic ext_scl_low,
  output logic sda_in,
  output logic scl_in
);
  // Wired-and: pull-up gives high unless some party pulls low
  assign sda_in = (sda_oe_n | sda_out) & !ext_sda_low;
  assign scl_in = (scl_oe_n | scl_out) & !ext_scl_low;
endmodule
`default_nettype wire

/* bench/spg_gpio_props.sv */
// Checker for the spare pin GPIO top: bus handshakes and pin drive.
// Assumes it is bound onto spg_gpio_top, ports watched by name.
`timescale 1ns/10ps
`default_nettype none
module spg_gpio_props
  import spg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic iface_select,
  input wire logic sda_out,
  input wire logic scl_out,
  input wire logic sda_oe_n,
  input wire logic scl_oe_n,
  input wire logic serial_data_in
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pin drive and reset state
  AST_OD_LOW: assert property (!sda_out && !scl_out)
    else $error("bus pin driven high");
  AST_RST_IDLE: assert property (!$past(aresetn) |->
    sda_oe_n && scl_oe_n && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
  // Write channel handshakes
  AST_B_NEXT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  AST_B_BUSY: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // Read channel handshakes
  AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or upper bits set");
  AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid)
    else $error("read answer stayed after taken");
  // Serial data route only under the I2C strap
  AST_SER_I2C: assert property (serial_data_in |->
    !$past(iface_select, 2) || !$past(iface_select, 3) ||
    !$past(iface_select, 4))
    else $error("serial data routed under SPI strap");
  // Main scenarios
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property ($fell(sda_oe_n));
endmodule
bind spg_gpio_top spg_gpio_props spg_gpio_props_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .s_axi_rdata,
  .iface_select, .sda_out, .scl_out, .sda_oe_n, .scl_oe_n,
  .serial_data_in);
`default_nettype wire

/* bench/spg_gpio_top_tb.sv */
// Testbench for the spare pin GPIO top: register rows, then pin levels,
// normal function, paging, refusals and a second reset.
// Assumes the pin model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module spg_gpio_top_tb;
  import spg_pkg::*;
  typedef struct packed {
    logic sel;
    logic [11:0] a;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [5:0] pins;
  } spg_row_type;
  localparam logic [11:0] AA = {2'h0, IDX_GPIO_A, 2'h0};
  localparam logic [11:0] AB = {2'h0, IDX_GPIO_B, 2'h0};
  localparam logic [11:0] AP = {2'h0, IDX_PAGE, 2'h0};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic iface_select = 1'b1, addr_bit0_pin = 1'b1, addr_bit1_pin = 1'b0;
  logic spare_input_pin = 1'b1, func_spare_out = 1'b0;
  logic func_spare_oe_n = 1'b1, func_sda_pull_low = 1'b0;
  logic func_scl_pull_low = 1'b0, ext_sda_low = 1'b0, ext_scl_low = 1'b0;
  logic sda_in, scl_in, sda_out, scl_out, sda_oe_n, scl_oe_n;
  logic serial_data_in, spare_output_pin, spare_output_oe_n;
  logic core_clock_use_plain;
  int errors = 0, check_count = 0;
  wire [5:0] pin_view = {sda_oe_n, scl_oe_n, spare_output_pin,
    spare_output_oe_n, serial_data_in, core_clock_use_plain};
  // Rows: strap, address, write, read back, pin outputs
  spg_row_type rows [10] = '{
    '{1'b1, AA, 8'h80, 8'h80, 6'h14}, '{1'b1, AA, 8'ha8, 8'ha8, 6'h24},
    '{1'b1, AA, 8'h44, 8'h55, 6'h34}, '{1'b1, AA, 8'h02, 8'h02, 6'h34},
    '{1'b0, AA, 8'h80, 8'h80, 6'h34}, '{1'b0, AB, 8'h37, 8'hbf, 6'h3b},
    '{1'b1, AB, 8'h37, 8'hb7, 6'h15}, '{1'b0, AB, 8'h00, 8'h80, 6'h34},
    '{1'b0, AB, 8'h26, 8'hae, 6'h38}, '{1'b0, AB, 8'h14, 8'h94, 6'h32}};

  spg_gpio_top spg_gpio_top_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .iface_select, .sda_in, .sda_out,
    .sda_oe_n, .scl_in, .scl_out, .scl_oe_n, .func_sda_pull_low,
    .func_scl_pull_low, .addr_bit0_pin, .addr_bit1_pin, .spare_input_pin,
    .serial_data_in, .spare_output_pin, .spare_output_oe_n,
    .func_spare_out, .func_spare_oe_n, .core_clock_use_plain);
  spg_pin_model spg_pin_model_i (.sda_out, .sda_oe_n, .scl_out,
    .scl_oe_n, .ext_sda_low, .ext_scl_low, .sda_in, .scl_in);

  // Clock, 50 ns period
  always #25 aclk = ~aclk;

  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait guard
  task automatic limit(input int n);
    if (n >= 40) begin
      errors++;
      $display("Error at %0t: bus wait ran out", $time);
      stop_test();
    end
  endtask

  // Bus write: both halves offered together, bready held high
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er, input logic [3:0] st);
    logic ad, wd;
    int n;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd) && n < 40) begin
      @(posedge aclk);
      n++;
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_bvalid && n < 40);
    limit(n);
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  // Bus read, rready held high
  task automatic rd(input logic [11:0] a, input logic [7:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < 40);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 40);
    limit(n);
    chk(s_axi_rdata, {24'h0, ed});
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      iface_select <= rows[i].sel;
      repeat (6) @(posedge aclk);
      wr(rows[i].a, rows[i].wd, RESP_OKAY, 4'h1);
      repeat (4) @(posedge aclk);
      rd(rows[i].a, rows[i].rd, RESP_OKAY);
      chk(32'(pin_view), 32'(rows[i].pins));
    end
    // Input levels follow an outside pull; masked write is dropped
    iface_select <= 1'b1;
    wr(AA, 8'h44, RESP_OKAY, 4'h1);
    ext_sda_low <= 1'b1;
    repeat (5) @(posedge aclk);
    rd(AA, 8'h45, RESP_OKAY);
    wr(AA, 8'h80, RESP_OKAY, 4'h0);
    rd(AA, 8'h45, RESP_OKAY);
    ext_sda_low <= 1'b0;
    // Normal function when not in general purpose use
    wr(AB, 8'h00, RESP_OKAY, 4'h1);
    iface_select <= 1'b0;
    func_sda_pull_low <= 1'b1;
    func_scl_pull_low <= 1'b1;
    func_spare_out <= 1'b1;
    func_spare_oe_n <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(32'(pin_view), 32'h08);
    // Page one hides both registers
    wr(AP, 8'h01, RESP_OKAY, 4'h1);
    rd(AP, 8'h01, RESP_OKAY);
    rd(AA, 8'h00, RESP_SLVERR);
    wr(AB, 8'h37, RESP_SLVERR, 4'h1);
    wr(AP, 8'h00, RESP_OKAY, 4'h1);
    rd(AB, 8'h80, RESP_OKAY);
    // Unmapped and misaligned places
    rd(12'h004, 8'h00, RESP_SLVERR);
    rd(AA + 12'h001, 8'h00, RESP_SLVERR);
    wr(12'h198, 8'h11, RESP_SLVERR, 4'h1);
    // Second reset with new strap levels
    addr_bit0_pin <= 1'b0;
    addr_bit1_pin <= 1'b1;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    chk(32'(pin_view), 32'h34);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(AA, 8'h00, RESP_OKAY);
    rd(AB, 8'h40, RESP_OKAY);
    stop_test();
  end
endmodule
`default_nettype wire
